// ==== ssc_baud.sv ====
`timescale 1ns/1ps
// Quarter-bit tick divider for master mode.
module ssc_baud
  import ssc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [7:0] divide,
  output logic tick
);
  logic [7:0] cnt_r;

  // Ticks once every divide+1 clocks, so four ticks give Fosc/(4*(n+1)).
  always_ff @(posedge clk) begin
    if (!rst_n || !run || cnt_r == divide) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign tick = run && (cnt_r == divide); // RULE8
endmodule

// ==== ssc_far_master.sv ====
// Far-side bus master model that drives the two open-drain lines.
`timescale 1ns/1ps
module ssc_far_master (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  output logic hung
);
  localparam int HALF = 10;
  // Both lines start released, so the pull-ups hold them high.
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    hung = 1'b0;
  end
  // Waits a number of clocks.
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Releases SCL and waits, with a bound, while a slave stretches it.
  task automatic rise();
    int n;
    n = 0;
    scl_pull <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (scl !== 1'b1 && n < 2000);
    if (n >= 2000) hung <= 1'b1;
    idle(HALF);
  endtask
  // Start: SDA falls while SCL is high.
  task automatic start();
    sda_pull <= 1'b1;
    idle(HALF);
    scl_pull <= 1'b1;
    idle(HALF);
  endtask
  // One bit; SDA moves only while SCL is low, read back at SCL high.
  task automatic bit_io(input logic v, output logic got);
    sda_pull <= !v;
    idle(HALF);
    rise();
    got = sda;
    scl_pull <= 1'b1;
    idle(2);
  endtask
  // Byte out, top bit first; ack is true when the slave pulled SDA low.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(b[i], g);
    bit_io(1'b1, g);
    ack = !g;
  endtask
  // Stop: SDA rises while SCL is high.
  task automatic stop();
    sda_pull <= 1'b1;
    idle(HALF);
    rise();
    sda_pull <= 1'b0;
    idle(HALF);
  endtask
endmodule

// ==== ssc_i2c.sv ====
`timescale 1ns/1ps
// I2C master and slave control of the synchronous serial port.
// How it works
// RULE1: ack value bit drives SDA on ack
// RULE2: sequence bits launch bus actions, self clear
// RULE3: sequence bits ignored while not idle
// RULE4: buffer writes blocked while not idle
// RULE5: slave mode start bit enables stretching
// RULE6: port works only with enable bit set
// RULE7: four bit mode field selects mode
// RULE8: SCL equals clock over 4*(divider+1)
// RULE9: firmware master mode keeps slave idle
// RULE10: pins open drain when enabled, inputs
// RULE11: slave drives SDA when transmitting; the code drives SDA only for the slave ack, and s_tx_r drives nothing
// RULE12: slave flags interrupt on address match
// RULE13: start/stop modes flag start and stop
// RULE14: slave acks and loads buffer on match
// RULE15: ack withheld if full or overflow
// RULE16: withheld byte not stored, flag still set
// RULE17: buffer read clears full, overflow by write
// RULE18: slave shifts 8 bits, compares bits 7:1
// RULE19: stretch holds SCL low after receive
// RULE20: master receive clears after byte stored
module ssc_i2c
  import ssc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  output logic SDA_OUT,
  output logic SDA_OE
);
  ssc_req_t req;
  ssc_pins_t drv;
  ssc_state_t st_r;
  logic [7:0] ctrl_r, seq_r, addr_r, dir_r, buf_r, sh_r, msh_r;
  logic bf_r, irq_r, tick, scl_m_r, sda_m_r;
  logic [1:0] q_r;
  logic [3:0] mbit_r, sbit_r;
  logic scl_d_r, sda_d_r, s_act_r, s_ack_r, s_tx_r, s_data_r, stretch_r;
  logic en, is_mst, is_fwm, is_slv, is_sp, pins_ok, idle, buf_wr;
  logic scl_rise, scl_fall, s_start, s_stop, s_hit, s_byte, s_ok;
  logic m_done;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign en = ctrl_r[CTRL_EN]; // RULE6
  // Mode decode from the control nibble.
  assign is_mst = en && ctrl_r[3:0] == MODE_MST; // RULE7
  assign is_fwm = en && ctrl_r[3:0] == MODE_FWM; // RULE7
  assign is_sp = ctrl_r[3:0] == MODE_S7SP || ctrl_r[3:0] == MODE_S10SP;
  assign is_slv = en && !is_fwm && (is_sp || ctrl_r[3:0] == MODE_S7 ||
                  ctrl_r[3:0] == MODE_S10); // RULE7 RULE9
  assign pins_ok = dir_r[DIR_SCL] && dir_r[DIR_SDA]; // RULE10 RULE11
  assign idle = st_r == SSC_IDLE && !(s_act_r && is_slv);
  assign buf_wr = req.wr && req.addr == OFF_BUF && idle; // RULE4

  ssc_baud u_baud (
    .clk(CLK),
    .rst_n(RST_N),
    .run(is_mst && st_r != SSC_IDLE),
    .divide(addr_r),
    .tick(tick)
  );

  // Control, address and direction registers.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_r <= RST_CTRL;
      addr_r <= RST_ADDR;
      dir_r <= RST_DIR;
    end else begin
      if (req.wr && req.addr == OFF_CTRL) begin
        ctrl_r <= req.wdata; // RULE17
      end
      // A refused byte meant for us sets overflow, winning over a write.
      if (s_byte && !s_ok && (s_data_r || s_hit)) begin
        ctrl_r[CTRL_OV] <= 1'b1;
      end
      if (req.wr && req.addr == OFF_ADDR) begin
        addr_r <= req.wdata;
      end
      if (req.wr && req.addr == OFF_DIR) begin
        dir_r <= req.wdata;
      end
    end
  end

  // Sequence bits: set only when idle outside slave mode, where the start bit is always writable; cleared by the sequencer.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      seq_r <= RST_SEQ;
    end else begin
      if (req.wr && req.addr == OFF_SEQ) begin
        seq_r[7:5] <= req.wdata[7:5];
        if (is_slv) begin
          seq_r[SEQ_START] <= req.wdata[SEQ_START]; // RULE5
        end else if (idle) begin
          seq_r[4:0] <= req.wdata[4:0]; // RULE3
        end
      end
      // The self clear must not be lost to a write in the same cycle.
      if (m_done) begin
        seq_r[4:0] <= 5'h00; // RULE2 RULE20
      end
    end
  end

  // Master sequencer stepping on quarter ticks.
  always_ff @(posedge CLK) begin
    if (!RST_N || !is_mst) begin
      st_r <= SSC_IDLE;
      q_r <= 2'h0;
      mbit_r <= 4'h0;
      scl_m_r <= 1'b1;
      sda_m_r <= 1'b1;
      msh_r <= 8'h00;
    end else if (st_r == SSC_IDLE) begin
      q_r <= 2'h0;
      mbit_r <= 4'h0;
      if (seq_r[SEQ_START]) begin
        st_r <= SSC_START; // RULE2
      end else if (seq_r[SEQ_RESTART]) begin
        st_r <= SSC_RSTRT;
      end else if (seq_r[SEQ_STOP]) begin
        st_r <= SSC_STOP;
      end else if (seq_r[SEQ_RECV]) begin
        st_r <= SSC_RECV;
      end else if (seq_r[SEQ_ACKGO]) begin
        st_r <= SSC_ACK;
      end else if (buf_wr) begin
        st_r <= SSC_WRITE;
        msh_r <= req.wdata;
      end
    end else if (tick) begin
      q_r <= q_r + 2'h1;
      case (st_r)
        SSC_START: begin
          sda_m_r <= q_r < 2'h1;
          scl_m_r <= q_r < 2'h2;
        end
        SSC_RSTRT: begin
          sda_m_r <= q_r < 2'h2;
          scl_m_r <= q_r != 2'h0 && q_r < QUARTERS;
        end
        SSC_STOP: begin
          sda_m_r <= q_r >= 2'h2;
          scl_m_r <= q_r != 2'h0;
        end
        SSC_ACK: begin
          sda_m_r <= seq_r[SEQ_ACKVAL]; // RULE1
          scl_m_r <= q_r == 2'h1 || q_r == 2'h2;
        end
        SSC_RECV: begin
          sda_m_r <= 1'b1;
          scl_m_r <= q_r == 2'h1 || q_r == 2'h2;
          if (q_r == 2'h2) begin
            msh_r <= {msh_r[6:0], SDA_IN};
          end
        end
        SSC_WRITE: begin
          sda_m_r <= mbit_r < BITS_PER_BYTE ? msh_r[7] : 1'b1;
          scl_m_r <= q_r == 2'h1 || q_r == 2'h2;
          if (q_r == QUARTERS && mbit_r < BITS_PER_BYTE) begin
            msh_r <= {msh_r[6:0], 1'b0};
          end
        end
        default: begin
          scl_m_r <= 1'b1;
          sda_m_r <= 1'b1;
        end
      endcase
      if (q_r == QUARTERS) begin
        mbit_r <= mbit_r + 4'h1;
        if (m_done) begin
          st_r <= SSC_IDLE;
        end
      end
    end
  end

  // A sequence ends after one bit slot, a byte after eight or nine.
  always_comb begin
    m_done = 1'b0;
    if (tick && q_r == QUARTERS) begin
      case (st_r)
        SSC_RECV: m_done = mbit_r == BITS_PER_BYTE - 4'h1; // RULE20
        SSC_WRITE: m_done = mbit_r == BITS_PER_BYTE;
        SSC_IDLE: m_done = 1'b0;
        default: m_done = 1'b1; // RULE2
      endcase
    end
  end

  // Slave bus watcher: edges, start and stop detection.
  assign scl_rise = SCL_IN && !scl_d_r;
  assign scl_fall = !SCL_IN && scl_d_r;
  assign s_start = SCL_IN && scl_d_r && sda_d_r && !SDA_IN;
  assign s_stop = SCL_IN && scl_d_r && !sda_d_r && SDA_IN;
  assign s_byte = is_slv && scl_fall && sbit_r == BITS_PER_BYTE && !s_ack_r;
  assign s_hit = sh_r[7:1] == addr_r[6:0]; // RULE18
  assign s_ok = !bf_r && !ctrl_r[CTRL_OV] && (s_data_r || s_hit); // RULE15

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= SCL_IN;
      sda_d_r <= SDA_IN;
    end
  end

  // Slave byte engine.
  always_ff @(posedge CLK) begin
    if (!RST_N || !is_slv || s_stop) begin
      s_act_r <= 1'b0;
      sbit_r <= 4'h0;
      sh_r <= 8'h00;
      s_ack_r <= 1'b0;
      s_tx_r <= 1'b0;
      s_data_r <= 1'b0;
      stretch_r <= 1'b0;
    end else if (s_start) begin
      s_act_r <= 1'b1;
      sbit_r <= 4'h0;
      s_data_r <= 1'b0;
      s_tx_r <= 1'b0;
    end else if (s_act_r) begin
      if (scl_rise && sbit_r < BITS_PER_BYTE) begin
        sh_r <= {sh_r[6:0], SDA_IN}; // RULE18
        sbit_r <= sbit_r + 4'h1;
      end
      // Count nine marks the ack slot, so a refused byte is seen once.
      if (s_byte) begin
        s_ack_r <= s_ok; // RULE14 RULE15
        sbit_r <= BITS_PER_BYTE + 4'h1;
        if (!s_data_r && s_ok) begin
          s_tx_r <= sh_r[0];
        end
        if (!s_ok && !s_data_r) begin
          s_act_r <= 1'b0;
        end
      end else if (sbit_r == BITS_PER_BYTE + 4'h1 && scl_fall) begin
        s_ack_r <= 1'b0;
        s_data_r <= 1'b1;
        sbit_r <= 4'h0;
        // Stretch starts as the ack slot ends, never inside it.
        stretch_r <= seq_r[SEQ_START] && s_ack_r; // RULE19
      end
      if (req.rd && req.addr == OFF_BUF) begin
        stretch_r <= 1'b0;
      end
    end
  end

  // Receive buffer and buffer-full flag; a set wins over a read.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      buf_r <= 8'h00;
      bf_r <= 1'b0;
    end else begin
      if (s_byte && s_ok) begin
        buf_r <= sh_r; // RULE14 RULE16
        bf_r <= 1'b1;
      end else if (m_done && st_r == SSC_RECV) begin
        buf_r <= msh_r; // RULE20
        bf_r <= 1'b1;
      end else if (buf_wr) begin
        buf_r <= req.wdata;
      end else if (req.rd && req.addr == OFF_BUF) begin
        bf_r <= 1'b0; // RULE17
      end
    end
  end

  // Port interrupt flag; hardware set wins over a software write.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_r <= 1'b0;
    end else if ((s_byte && (s_data_r || s_hit)) || m_done ||
                 (is_slv && is_sp && (s_start || s_stop))) begin
      irq_r <= 1'b1; // RULE12 RULE13 RULE16
    end else if (req.wr && req.addr == OFF_IRQ) begin
      irq_r <= req.wdata[IRQ_PORT];
    end
  end

  // Read data, valid in the cycle after the read strobe.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        OFF_CTRL: RDATA <= ctrl_r;
        OFF_SEQ: RDATA <= seq_r;
        OFF_STAT: RDATA <= {7'h00, bf_r};
        OFF_BUF: RDATA <= buf_r;
        OFF_ADDR: RDATA <= addr_r;
        OFF_IRQ: RDATA <= {4'h0, irq_r, 3'h0};
        OFF_DIR: RDATA <= dir_r;
        default: RDATA <= 8'h00;
      endcase
    end
  end

  // Open-drain drive: enable pulls the pin low.
  always_comb begin
    drv.scl_oe = 1'b0;
    drv.sda_oe = 1'b0;
    if (en && pins_ok) begin // RULE10
      if (is_mst) begin
        drv.scl_oe = !scl_m_r;
        drv.sda_oe = !sda_m_r; // RULE1 RULE2
      end else if (is_slv) begin
        drv.sda_oe = s_ack_r; // RULE14 RULE11
        drv.scl_oe = stretch_r && !SCL_IN; // RULE19 RULE5
      end
    end
  end
  assign SCL_OE = drv.scl_oe;
  assign SDA_OE = drv.sda_oe;
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;

  a_seq_ignore: assert property (@(posedge CLK) disable iff (!RST_N) // RULE3
    (req.wr && req.addr == OFF_SEQ && !idle && !is_slv && !m_done)
      |=> seq_r[4:0] == $past(seq_r[4:0]))
    else $error("Sequence bit set while busy.");
  a_full_set: assert property (@(posedge CLK) disable iff (!RST_N) // RULE14
    (s_byte && s_ok) |=> bf_r && buf_r == $past(sh_r))
    else $error("Matched byte not stored.");
  a_nack_keep: assert property (@(posedge CLK) disable iff (!RST_N) // RULE16
    (s_byte && !s_ok && !is_mst) |=> buf_r == $past(buf_r) && irq_r ||
      !$past(s_data_r || s_hit))
    else $error("Refused byte changed buffer.");
  a_bf_read: assert property (@(posedge CLK) disable iff (!RST_N) // RULE17
    (req.rd && req.addr == OFF_BUF && !s_byte && !m_done) |=> !bf_r)
    else $error("Buffer read kept full flag.");
  a_buf_block: assert property (@(posedge CLK) disable iff (!RST_N) // RULE4
    (req.wr && req.addr == OFF_BUF && !idle && !s_byte && !m_done)
      |=> buf_r == $past(buf_r))
    else $error("Buffer written while busy.");
  a_pins_off: assert property (@(posedge CLK) disable iff (!RST_N) // RULE6
    !en |-> !SCL_OE && !SDA_OE)
    else $error("Pins driven while disabled.");
  a_fwm_quiet: assert property (@(posedge CLK) disable iff (!RST_N) // RULE9
    is_fwm |-> !SDA_OE && !s_act_r)
    else $error("Slave active in firmware master mode.");
  a_ack_low: assert property (@(posedge CLK) disable iff (!RST_N) // RULE1
    (st_r == SSC_ACK && tick && q_r == 2'h1 && pins_ok)
      |=> SDA_OE == !seq_r[SEQ_ACKVAL])
    else $error("Ack value not driven.");
endmodule

// ==== ssc_i2c_tb.sv ====
// Self-checking bench for the serial port's bus control logic.
`timescale 1ns/1ps
module ssc_i2c_tb
  import ssc_pkg::*;
;
  localparam int DIV = 3;
  logic CLK, RST_N, WR, RD, rd_d, scl_q, sda_q, ack, k;
  logic [2:0] ADDR;
  logic [7:0] WDATA, RDATA, a, d;
  logic SCL_OE, SDA_OE, m_scl, m_sda, hung;
  logic [7:0] exp_q[$];
  logic [7:0] t_ctrl[6] = '{8'h26, 8'h2e, 8'h2f, 8'h27, 8'h2b, 8'h26};
  logic [7:0] t_irq[6] = '{8'h00, 8'h08, 8'h08, 8'h08, 8'h00, 8'h00};
  logic t_ack[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  int bad_count, tests_run, n;
  wire scl = !(SCL_OE || m_scl);
  wire sda = !(SDA_OE || m_sda);
  // Clock with a 20 ns period.
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  ssc_i2c i_dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SCL_IN(scl_q), .SDA_IN(sda_q),
    .SCL_OUT(), .SCL_OE(SCL_OE), .SDA_OUT(), .SDA_OE(SDA_OE));
  ssc_far_master i_far (.clk(CLK), .scl(scl), .sda(sda),
    .scl_pull(m_scl), .sda_pull(m_sda), .hung(hung));
  // Line levels are resampled, which also breaks any loop through OE.
  always @(posedge CLK) begin
    scl_q <= scl;
    sda_q <= sda;
    rd_d <= RD;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    tests_run++;
    if (seen !== expv) begin
      bad_count++;
      $display("ERROR %0t: saw %h, wanted %h", $time, seen, expv);
    end
  endtask
  // Read data are compared with the oldest note on the queue.
  always @(posedge CLK) if (rd_d) check(RDATA, exp_q.pop_front());
  // A hang on the far side ends the run as a failure.
  always @(posedge CLK) begin
    if (hung === 1'b1) begin
      bad_count++;
      conclude();
    end
  end
  // One-cycle register write.
  task automatic wr_reg(input logic [2:0] ad, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= ad;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // One-cycle register read; the expected data go on the queue.
  task automatic rd_exp(input logic [2:0] ad, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= ad;
    RD <= 1'b1;
    exp_q.push_back(v);
    @(posedge CLK);
    RD <= 1'b0;
  endtask
  // Counts clocks until the chosen output enable goes high.
  task automatic span(input bit pick_scl, output int cnt);
    cnt = 0;
    do begin
      @(posedge CLK);
      #1;
      cnt++;
    end while ((pick_scl ? SCL_OE : SDA_OE) !== 1'b1 && cnt < 100);
    if (cnt >= 100) begin
      bad_count++;
      conclude();
    end
  endtask
  // Main sequence: slave traffic, mode table, then master sequences.
  initial begin
    RST_N = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 3'h0;
    WDATA = 8'h00;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(20));
    a = {1'b0, 7'($urandom())};
    d = 8'($urandom());
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd_exp(OFF_CTRL, RST_CTRL);
    rd_exp(OFF_SEQ, RST_SEQ);
    rd_exp(OFF_ADDR, RST_ADDR);
    rd_exp(OFF_DIR, RST_DIR);
    rd_exp(3'h7, 8'h00);
    wr_reg(OFF_ADDR, a);
    wr_reg(OFF_CTRL, {4'h0, MODE_S7});
    i_far.start();
    i_far.put_byte({a[6:0], 1'b0}, ack);
    i_far.stop();
    check(8'(ack), 8'h00);
    wr_reg(OFF_CTRL, {4'h2, MODE_S7});
    i_far.start();
    i_far.put_byte({a[6:0], 1'b0}, ack);
    check(8'(ack), 8'h01);
    i_far.put_byte(d, ack);
    check(8'(ack), 8'h00);
    i_far.stop();
    rd_exp(OFF_IRQ, 8'h08);
    rd_exp(OFF_STAT, 8'h01);
    rd_exp(OFF_BUF, {a[6:0], 1'b0});
    rd_exp(OFF_STAT, 8'h00);
    rd_exp(OFF_CTRL, 8'h66);
    wr_reg(OFF_CTRL, 8'h26);
    rd_exp(OFF_CTRL, 8'h26);
    wr_reg(OFF_SEQ, 8'h01);
    i_far.start();
    i_far.put_byte({a[6:0], 1'b0}, ack);
    rd_exp(OFF_BUF, {a[6:0], 1'b0});
    i_far.put_byte(d, ack);
    check(8'(ack), 8'h01);
    repeat (4) @(posedge CLK);
    check(8'(SCL_OE), 8'h01);
    rd_exp(OFF_BUF, d);
    repeat (4) @(posedge CLK);
    check(8'(SCL_OE), 8'h00);
    i_far.stop();
    wr_reg(OFF_SEQ, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr_reg(OFF_IRQ, 8'h00);
      wr_reg(OFF_DIR, (i == 5) ? 8'he7 : 8'hff);
      wr_reg(OFF_CTRL, t_ctrl[i]);
      i_far.start();
      ack = 1'b0;
      if (i >= 3) i_far.put_byte({a[6:0], 1'b0}, ack);
      i_far.stop();
      check(8'(ack), 8'(t_ack[i]));
      if (i < 5) rd_exp(OFF_IRQ, t_irq[i]);
      if (t_ack[i]) rd_exp(OFF_BUF, {a[6:0], 1'b0});
    end
    wr_reg(OFF_DIR, 8'hff);
    wr_reg(OFF_ADDR, 8'(DIV));
    wr_reg(OFF_CTRL, {4'h2, MODE_MST});
    wr_reg(OFF_SEQ, 8'h01);
    span(1'b0, n);
    span(1'b1, n);
    check(8'(n), 8'(DIV + 1));
    repeat (20) @(posedge CLK);
    rd_exp(OFF_SEQ, 8'h00);
    wr_reg(OFF_SEQ, 8'h04);
    repeat (3) @(posedge CLK);
    wr_reg(OFF_SEQ, 8'h02);
    wr_reg(OFF_BUF, 8'h3c);
    repeat (40) @(posedge CLK);
    rd_exp(OFF_SEQ, 8'h00);
    check(8'(SDA_OE), 8'h00);
    rd_exp(OFF_BUF, {a[6:0], 1'b0});
    for (int v = 1; v >= 0; v--) begin
      wr_reg(OFF_SEQ, {2'b00, v[0], 5'h10});
      k = 1'b0;
      repeat (40) begin
        @(posedge CLK);
        #1;
        if (SDA_OE === 1'b1) k = 1'b1;
      end
      check(8'(k), 8'(!v[0]));
      rd_exp(OFF_SEQ, {2'b00, v[0], 5'h00});
    end
    // Master receive of a released line: eight ones, then self clear.
    wr_reg(OFF_SEQ, 8'h08);
    repeat (150) @(posedge CLK);
    rd_exp(OFF_SEQ, 8'h00);
    rd_exp(OFF_BUF, 8'hff);
    repeat (3) @(posedge CLK);
    conclude();
  end
endmodule

// ==== ssc_pkg.sv ====
// Package with register map, fields, modes and states of the serial port.
package ssc_pkg;
  // Register offsets on the plain register port.
  localparam logic [2:0] OFF_CTRL = 3'h0;
  localparam logic [2:0] OFF_SEQ = 3'h1;
  localparam logic [2:0] OFF_STAT = 3'h2;
  localparam logic [2:0] OFF_BUF = 3'h3;
  localparam logic [2:0] OFF_ADDR = 3'h4;
  localparam logic [2:0] OFF_IRQ = 3'h5;
  localparam logic [2:0] OFF_DIR = 3'h6;
  // Field positions.
  localparam int SEQ_START = 0;
  localparam int SEQ_RESTART = 1;
  localparam int SEQ_STOP = 2;
  localparam int SEQ_RECV = 3;
  localparam int SEQ_ACKGO = 4;
  localparam int SEQ_ACKVAL = 5;
  localparam int CTRL_EN = 5;
  localparam int CTRL_OV = 6;
  localparam int STAT_BF = 0;
  localparam int IRQ_PORT = 3;
  localparam int DIR_SCL = 3;
  localparam int DIR_SDA = 4;
  // Reset values.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_SEQ = 8'h00;
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  // Mode codes in the low nibble of the control register.
  localparam logic [3:0] MODE_S7 = 4'h6;
  localparam logic [3:0] MODE_S10 = 4'h7;
  localparam logic [3:0] MODE_MST = 4'h8;
  localparam logic [3:0] MODE_FWM = 4'hb;
  localparam logic [3:0] MODE_S7SP = 4'he;
  localparam logic [3:0] MODE_S10SP = 4'hf;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Last master phase index per bit: the SCL period is four quarter ticks.
  localparam logic [1:0] QUARTERS = 2'h3;
  // Master sequencer states.
  typedef enum logic [6:0] {
    SSC_IDLE  = 7'h01,
    SSC_START = 7'h02,
    SSC_RSTRT = 7'h04,
    SSC_STOP  = 7'h08,
    SSC_RECV  = 7'h10,
    SSC_ACK   = 7'h20,
    SSC_WRITE = 7'h40
  } ssc_state_t;
  // Register port request.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ssc_req_t;
  // Pin drive set: output enables only, open drain pulls low.
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } ssc_pins_t;
endpackage
